// [trf_report_filter.sv]
// Functional notes
// [R1] parameter byte is counts plus 32, 0..95
// [R2] host sends I then one parameter byte
// [R3] report only after moving increment in X/Y
// [R4] increment zero disables increment filtering
// [R5] point mode overrides both filters
// [R6] remote trigger: fresh if met, else resend
// [R7] stream: report only when met, rate limited
// [R8] stream: press and release resend last report
// [R9] switch stream: one report on unmet press
// [R10] G plus offset byte sets axis step
// [R11] axis step zero disables axis filtering
// [R12] first sample after enabling becomes reference
// [R13] met axis updates, unmet axis repeats value
// [R14] no two identical fresh axis reports
// [R15] grid coordinates are reference plus step multiples
// [R16] single-byte commands pick predefined resolution
// [R17] resolution defaults to 200 lpi
// [R18] increment query reports current increment
// [R19] out-of-range parameter keeps old setting
`timescale 1ns/100ps
module trf_report_filter
  import trf_pkg::*;
(
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  // command link
  input  wire logic                      cmd_valid,
  input  wire logic [7:0]                cmd_byte,
  input  wire logic                      reset_cmd,
  // report flow control
  input  wire trf_pkg::trf_mode_e        report_mode,
  input  wire logic                      trigger,
  input  wire logic                      rate_tick,
  // digitiser samples
  input  wire logic                      sample_valid,
  input  wire trf_pkg::trf_point_s       sample_pos,
  input  wire logic                      prox,
  input  wire logic [2:0]                buttons,
  // reports
  output trf_pkg::trf_report_s           report,
  output logic                           report_valid,
  // settings
  output logic [trf_pkg::TRF_STEP_W-1:0] increment_step,
  output logic [trf_pkg::TRF_STEP_W-1:0] axis_step,
  output logic [trf_pkg::TRF_RES_W-1:0]  resolution_lpi,
  // query answer
  output logic                           query_valid,
  output logic [7:0]                     query_value
);
  import trf_pkg::*;

  logic                  inc_wr;
  logic                  axis_wr;
  logic [TRF_STEP_W-1:0] step_val;
  logic                  res_wr;
  logic [TRF_RES_W-1:0]  res_lpi;
  logic                  query_pulse;

  trf_point_s  cur;
  trf_report_s last_rep;
  trf_point_s  fresh;
  logic        fresh_pend;
  logic        ref_pend;
  logic        btn_prev;

  trf_point_s  base;
  logic        inc_x;
  logic        inc_y;
  logic        grid_x;
  logic        grid_y;
  trf_point_s  grid_pos;
  logic        filt_on;
  logic        btn_held;
  logic        btn_press;
  logic        btn_release;
  logic        send_fresh;
  logic        send_last;
  logic        send_cur;
  logic        fresh_set;
  trf_point_s  next_fresh;
  logic        fresh_new;

  trf_cmd_parser u_parser (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .cmd_valid   (cmd_valid),
    .cmd_byte    (cmd_byte),
    .inc_wr      (inc_wr),
    .axis_wr     (axis_wr),
    .step_val    (step_val),
    .res_wr      (res_wr),
    .res_lpi     (res_lpi),
    .query_pulse (query_pulse)
  );

  trf_axis_filter #(.W(TRF_COORD_W)) u_filt_x (
    .cur       (sample_pos.x),
    .base      (base.x),
    .inc_step  (increment_step),
    .grid_step (axis_step),
    .inc_met   (inc_x),
    .grid_met  (grid_x),
    .grid_next (grid_pos.x)
  );

  trf_axis_filter #(.W(TRF_COORD_W)) u_filt_y (
    .cur       (sample_pos.y),
    .base      (base.y),
    .inc_step  (increment_step),
    .grid_step (axis_step),
    .inc_met   (inc_y),
    .grid_met  (grid_y),
    .grid_next (grid_pos.y)
  );

  assign base        = fresh_pend ? fresh : last_rep.pos;
  assign filt_on     = (increment_step != TRF_STEP_RESET) || (axis_step != TRF_STEP_RESET);
  assign btn_held    = |buttons;
  assign btn_press   = btn_held && !btn_prev;
  assign btn_release = !btn_held && btn_prev;
  // a point equal to the one about to stand as last report is not news
  assign fresh_new   = next_fresh != (send_fresh ? fresh : last_rep.pos); // [R14]

  // settings
  always_ff @(posedge clk) begin
    if (sys_rst || reset_cmd) begin
      increment_step <= TRF_STEP_RESET;
      axis_step      <= TRF_STEP_RESET;
      resolution_lpi <= TRF_RES_DEFAULT; // [R17]
    end else begin
      if (inc_wr) begin
        increment_step <= step_val; // [R1] [R4] [R19]
      end
      if (axis_wr) begin
        axis_step <= step_val; // [R10] [R11] [R19]
      end
      if (res_wr) begin
        resolution_lpi <= res_lpi; // [R16]
      end
    end
  end

  // query answer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      query_valid <= 1'b0;
      query_value <= TRF_PARAM_OFFSET;
    end else begin
      query_valid <= query_pulse;                                          // [R18]
      query_value <= TRF_PARAM_OFFSET + {1'b0, increment_step}; // [R18]
    end
  end

  // sample capture and button edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cur      <= '0;
      btn_prev <= 1'b0;
    end else begin
      btn_prev <= btn_held;
      if (sample_valid) begin
        cur <= sample_pos;
      end
    end
  end

  // threshold evaluation on each new sample
  always_comb begin
    fresh_set  = 1'b0;
    next_fresh = fresh;
    if (sample_valid && filt_on && (report_mode != TRF_MODE_POINT)) begin // [R5]
      if (ref_pend) begin
        fresh_set  = 1'b1;
        next_fresh = sample_pos; // [R12]
      end else if (axis_step != TRF_STEP_RESET) begin
        if (grid_x || grid_y) begin
          fresh_set    = 1'b1;
          next_fresh.x = grid_x ? grid_pos.x : base.x; // [R13]
          next_fresh.y = grid_y ? grid_pos.y : base.y; // [R13]
        end
      end else if (inc_x || inc_y) begin
        fresh_set  = 1'b1;
        next_fresh = sample_pos; // [R3]
      end
    end
  end

  // report decision per flow mode
  always_comb begin
    send_fresh = 1'b0;
    send_last  = 1'b0;
    send_cur   = 1'b0;
    case (report_mode)
      TRF_MODE_POINT: begin
        send_cur = btn_press; // [R5]
      end
      TRF_MODE_REMOTE: begin
        if (trigger) begin
          if (!filt_on) begin
            send_cur = 1'b1;
          end else if (fresh_pend) begin
            send_fresh = 1'b1; // [R6]
          end else begin
            send_last = 1'b1; // [R6]
          end
        end
      end
      TRF_MODE_STREAM: begin
        if (!filt_on) begin
          send_cur = rate_tick;
        end else if (btn_press || btn_release) begin
          send_last = 1'b1; // [R8]
        end else begin
          send_fresh = rate_tick && fresh_pend; // [R7]
        end
      end
      TRF_MODE_SWITCH: begin
        if (!filt_on) begin
          send_cur = btn_held && rate_tick;
        end else if (btn_press && !fresh_pend) begin
          send_last = 1'b1; // [R9]
        end else begin
          send_fresh = btn_held && rate_tick && fresh_pend; // [R9]
        end
      end
      default: begin
        send_cur = 1'b0;
      end
    endcase
  end

  // pending fresh point; a new threshold hit wins over the send
  always_ff @(posedge clk) begin
    if (sys_rst || reset_cmd) begin
      fresh      <= '0;
      fresh_pend <= 1'b0;
      ref_pend   <= 1'b0;
    end else begin
      if (inc_wr || axis_wr) begin
        ref_pend <= (step_val != TRF_STEP_RESET); // [R12]
      end else if (fresh_set) begin
        ref_pend <= 1'b0;
      end
      if (!filt_on) begin
        fresh_pend <= 1'b0; // [R4] [R11]
      end else if (fresh_set) begin
        fresh_pend <= fresh_new; // [R14]
        fresh      <= next_fresh;
      end else if (send_fresh || send_cur) begin
        fresh_pend <= 1'b0;
      end
    end
  end

  // report output
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      report_valid <= 1'b0;
      report       <= '0;
      last_rep     <= '0;
    end else begin
      report_valid <= send_fresh || send_last || send_cur;
      if (send_cur) begin
        report       <= '{pos: cur, prox: prox, buttons: buttons};
        last_rep     <= '{pos: cur, prox: prox, buttons: buttons};
      end else if (send_fresh) begin
        report       <= '{pos: fresh, prox: prox, buttons: buttons}; // [R6] [R7]
        last_rep     <= '{pos: fresh, prox: prox, buttons: buttons};
      end else if (send_last) begin
        report       <= '{pos: last_rep.pos, prox: prox, buttons: buttons}; // [R8]
        last_rep.buttons <= buttons;
      end
    end
  end

  // checks
  inc_sequence_a: assert property (@(posedge clk) disable iff (sys_rst || reset_cmd) // [R2]
    (cmd_valid && cmd_byte == TRF_CMD_INCR && u_parser.state == 4'h1) ##1
    (cmd_valid && cmd_byte >= TRF_PARAM_OFFSET && cmd_byte <= TRF_PARAM_MAX)
    |-> ##2 (increment_step == 7'($past(cmd_byte, 2) - TRF_PARAM_OFFSET)))
    else $error("increment byte not applied");
  param_write_a: assert property (@(posedge clk) disable iff (sys_rst || reset_cmd) // [R1]
    inc_wr |=> increment_step == $past(step_val))
    else $error("increment step not stored");
  reject_keep_a: assert property (@(posedge clk) disable iff (sys_rst || reset_cmd) // [R19]
    !inc_wr && !axis_wr |=> increment_step == $past(increment_step)
                            && axis_step == $past(axis_step))
    else $error("setting changed without valid write");
  point_override_a: assert property (@(posedge clk) disable iff (sys_rst) // [R5]
    report_valid && $past(report_mode) == TRF_MODE_POINT |-> $past(btn_press))
    else $error("point mode report without press");
  remote_answer_a: assert property (@(posedge clk) disable iff (sys_rst) // [R6]
    report_mode == TRF_MODE_REMOTE && trigger && filt_on && !fresh_pend
    |=> report_valid && report.pos == $past(last_rep.pos))
    else $error("trigger did not resend last report");
  stream_rate_a: assert property (@(posedge clk) disable iff (sys_rst) // [R7]
    report_valid && $past(report_mode) == TRF_MODE_STREAM && $past(filt_on)
    && !$past(btn_press || btn_release) |-> $past(rate_tick) && $past(fresh_pend))
    else $error("stream report outside rate or unmet");
  release_resend_a: assert property (@(posedge clk) disable iff (sys_rst) // [R8]
    report_mode == TRF_MODE_STREAM && filt_on && btn_release
    |=> report_valid && report.buttons == 3'h0 && report.pos == $past(last_rep.pos))
    else $error("release did not resend last report");
  switch_press_a: assert property (@(posedge clk) disable iff (sys_rst) // [R9]
    report_mode == TRF_MODE_SWITCH && filt_on && btn_press && !fresh_pend
    |=> report_valid ##1 (!report_valid || $past(fresh_pend)))
    else $error("switch stream press not one report");
  filter_off_a: assert property (@(posedge clk) disable iff (sys_rst) // [R4]
    !filt_on |=> !fresh_pend) // [R11]
    else $error("fresh point pending with filters off");
  no_repeat_a: assert property (@(posedge clk) disable iff (sys_rst) // [R14]
    send_fresh && axis_step != TRF_STEP_RESET |-> fresh != last_rep.pos)
    else $error("identical axis report repeated");
  query_answer_a: assert property (@(posedge clk) disable iff (sys_rst) // [R18]
    query_pulse |=> query_valid && query_value == TRF_PARAM_OFFSET + {1'b0, increment_step})
    else $error("query answer wrong");
  res_select_a: assert property (@(posedge clk) disable iff (sys_rst || reset_cmd) // [R16]
    res_wr |=> resolution_lpi == $past(res_lpi))
    else $error("resolution not selected");

  remote_fresh_c: cover property (@(posedge clk) disable iff (sys_rst)
    report_mode == TRF_MODE_REMOTE && trigger && fresh_pend);
  stream_fresh_c: cover property (@(posedge clk) disable iff (sys_rst)
    report_mode == TRF_MODE_STREAM && send_fresh);
  axis_ref_c: cover property (@(posedge clk) disable iff (sys_rst)
    ref_pend && fresh_set && axis_step != TRF_STEP_RESET);
  query_c: cover property (@(posedge clk) disable iff (sys_rst) query_valid);

endmodule

// [trf_pkg.sv]
package trf_pkg;

  // command bytes
  localparam logic [7:0] TRF_CMD_INCR     = 8'h49;
  localparam logic [7:0] TRF_CMD_AXIS     = 8'h47;
  localparam logic [7:0] TRF_CMD_QUERY_Z  = 8'h7A;
  localparam logic [7:0] TRF_CMD_QUERY_I  = 8'h69;

  // parameter byte encoding
  localparam logic [7:0] TRF_PARAM_OFFSET = 8'h20;
  localparam logic [7:0] TRF_PARAM_MAX    = 8'h7F;

  localparam int         TRF_COORD_W      = 16;
  localparam int         TRF_STEP_W       = 7;
  localparam int         TRF_RES_W        = 11;

  localparam logic [6:0]  TRF_STEP_RESET  = 7'h00;
  localparam logic [10:0] TRF_RES_DEFAULT = 11'h0C8;

  typedef enum logic [3:0] {
    TRF_MODE_POINT  = 4'h1,
    TRF_MODE_REMOTE = 4'h2,
    TRF_MODE_STREAM = 4'h4,
    TRF_MODE_SWITCH = 4'h8
  } trf_mode_e;

  typedef struct packed {
    logic [TRF_COORD_W-1:0] x;
    logic [TRF_COORD_W-1:0] y;
  } trf_point_s;

  typedef struct packed {
    trf_point_s pos;
    logic       prox;
    logic [2:0] buttons;
  } trf_report_s;

  typedef struct packed {
    logic                 hit;
    logic [TRF_RES_W-1:0] lpi;
  } trf_res_s;

  function automatic trf_res_s trf_res_lookup(input logic [7:0] code);
    trf_res_s r;
    r.hit = 1'b1;
    case (code)
      8'h6C:   r.lpi = 11'h001;
      8'h6E:   r.lpi = 11'h002;
      8'h70:   r.lpi = 11'h004;
      8'h64:   r.lpi = 11'h064;
      8'h65:   r.lpi = 11'h0C8;
      8'h66:   r.lpi = 11'h0FE;
      8'h67:   r.lpi = 11'h190;
      8'h68:   r.lpi = 11'h1F4;
      8'h69:   r.lpi = 11'h1FC;
      8'h6A:   r.lpi = 11'h3E8;
      8'h71:   r.lpi = 11'h3F8;
      default: begin
        r.hit = 1'b0;
        r.lpi = TRF_RES_DEFAULT;
      end
    endcase
    return r;
  endfunction

endpackage

// [trf_cmd_parser.sv]
`timescale 1ns/100ps
module trf_cmd_parser
  import trf_pkg::*;
(
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  // command byte stream
  input  wire logic                 cmd_valid,
  input  wire logic [7:0]           cmd_byte,
  // decoded actions
  output logic                      inc_wr,
  output logic                      axis_wr,
  output logic [TRF_STEP_W-1:0]     step_val,
  output logic                      res_wr,
  output logic [TRF_RES_W-1:0]      res_lpi,
  output logic                      query_pulse
);

  typedef enum logic [3:0] {
    TRF_PS_IDLE = 4'h1,
    TRF_PS_INC  = 4'h2,
    TRF_PS_AXIS = 4'h4,
    TRF_PS_Z    = 4'h8
  } trf_pstate_e;

  trf_pstate_e state;
  logic        in_range;
  logic [7:0]  diff;
  trf_res_s    res;

  assign in_range = (cmd_byte >= TRF_PARAM_OFFSET) && (cmd_byte <= TRF_PARAM_MAX);
  assign diff     = cmd_byte - TRF_PARAM_OFFSET;
  assign res      = trf_res_lookup(cmd_byte);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= TRF_PS_IDLE;
    end else if (cmd_valid) begin
      case (state)
        TRF_PS_IDLE: begin
          if (cmd_byte == TRF_CMD_INCR) begin
            state <= TRF_PS_INC; // [R2] [R3]
          end else if (cmd_byte == TRF_CMD_AXIS) begin
            state <= TRF_PS_AXIS; // [R10]
          end else if (cmd_byte == TRF_CMD_QUERY_Z) begin
            state <= TRF_PS_Z;
          end
        end
        default: state <= TRF_PS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      inc_wr      <= 1'b0;
      axis_wr     <= 1'b0;
      step_val    <= TRF_STEP_RESET;
      res_wr      <= 1'b0;
      res_lpi     <= TRF_RES_DEFAULT;
      query_pulse <= 1'b0;
    end else begin
      inc_wr      <= cmd_valid && (state == TRF_PS_INC) && in_range;  // [R1] [R19]
      axis_wr     <= cmd_valid && (state == TRF_PS_AXIS) && in_range; // [R10] [R19]
      step_val    <= diff[TRF_STEP_W-1:0];                            // [R1] [R10]
      res_wr      <= cmd_valid && (state == TRF_PS_IDLE) && res.hit;  // [R16]
      res_lpi     <= res.lpi;
      query_pulse <= cmd_valid && (state == TRF_PS_Z) && (cmd_byte == TRF_CMD_QUERY_I); // [R18]
    end
  end

endmodule

// [trf_axis_filter.sv]
`timescale 1ns/100ps
module trf_axis_filter #(
  parameter int W = 16
) (
  // positions
  input  wire logic [W-1:0] cur,
  input  wire logic [W-1:0] base,
  // thresholds
  input  wire logic [6:0]   inc_step,
  input  wire logic [6:0]   grid_step,
  // decisions
  output logic              inc_met,
  output logic              grid_met,
  output logic [W-1:0]      grid_next
);

  logic         neg;
  logic [W-1:0] mag;
  logic [W-1:0] inc_w;
  logic [W-1:0] grid_w;

  assign neg       = cur < base;
  assign mag       = neg ? (base - cur) : (cur - base);
  assign inc_w     = W'(inc_step);
  assign grid_w    = W'(grid_step);
  assign inc_met   = (inc_step != 7'h00) && (mag >= inc_w);   // [R3] [R4]
  assign grid_met  = (grid_step != 7'h00) && (mag >= grid_w); // [R11] [R13]
  // one grid step per sample keeps the value on the lattice
  assign grid_next = neg ? (base - grid_w) : (base + grid_w); // [R15]

endmodule

// [trf_host_model.sv]
`timescale 1ns/100ps
module trf_host_model
  import trf_pkg::*;
(
  // clock
  input  wire logic  clk,
  // command byte stream
  output logic       cmd_valid,
  output logic [7:0] cmd_byte
);
  initial begin
    cmd_valid = 1'b0;
    cmd_byte  = 8'h00;
  end

  // one strobe per byte; released line shows the inverse
  task automatic send(input logic [7:0] b);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_byte  = b;
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd_byte  = ~b;
  endtask

  task automatic send_setting(input logic [7:0] cmd, input logic [6:0] counts);
    send(cmd);
    send({1'b0, counts} + TRF_PARAM_OFFSET);
  endtask
endmodule

// [trf_report_filter_test.sv]
`timescale 1ns/100ps
module trf_report_filter_test;
  import trf_pkg::*;
  logic                  clk;
  logic                  sys_rst;
  logic                  cmd_valid;
  logic [7:0]            cmd_byte;
  logic                  reset_cmd;
  trf_mode_e             report_mode;
  logic                  trigger;
  logic                  rate_tick;
  logic                  sample_valid;
  trf_point_s            sample_pos;
  logic                  prox;
  logic [2:0]            buttons;
  trf_report_s           report;
  logic                  report_valid;
  logic [TRF_STEP_W-1:0] increment_step;
  logic [TRF_STEP_W-1:0] axis_step;
  logic [TRF_RES_W-1:0]  resolution_lpi;
  logic                  query_valid;
  logic [7:0]            query_value;
  logic [7:0]            qv;
  logic [6:0]            v;
  int                    n_fail;
  int                    checked;
  localparam logic [7:0]  RES_CODE [11] = '{8'h6C, 8'h6E, 8'h70, 8'h64, 8'h65, 8'h66,
                                            8'h67, 8'h68, 8'h69, 8'h6A, 8'h71};
  localparam logic [10:0] RES_LPI [11]  = '{11'd1, 11'd2, 11'd4, 11'd100, 11'd200, 11'd254,
                                            11'd400, 11'd500, 11'd508, 11'd1000, 11'd1016};

  trf_host_model i_host (.clk(clk), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte));

  trf_report_filter i_dut (
    .clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
    .reset_cmd(reset_cmd), .report_mode(report_mode), .trigger(trigger),
    .rate_tick(rate_tick), .sample_valid(sample_valid), .sample_pos(sample_pos),
    .prox(prox), .buttons(buttons), .report(report), .report_valid(report_valid),
    .increment_step(increment_step), .axis_step(axis_step),
    .resolution_lpi(resolution_lpi), .query_valid(query_valid),
    .query_value(query_value)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [7:0] query_exp(input logic [6:0] s);
    return {1'b0, s} + 8'h20;
  endfunction

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [35:0] got, input logic [35:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic samp(input logic [15:0] x, input logic [15:0] y);
    @(negedge clk);
    sample_pos   = '{x: x, y: y};
    sample_valid = 1'b1;
    @(negedge clk);
    sample_valid = 1'b0;
    idle(2);
  endtask

  task automatic strobe(input logic use_tick);
    @(negedge clk);
    if (use_tick) begin
      rate_tick = 1'b1;
    end else begin
      trigger = 1'b1;
    end
  endtask

  // watch a short window for reports; strobes drop at its first falling edge
  task automatic watch(input logic want, input logic [15:0] x, input logic [15:0] y,
                       input logic [2:0] b);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      trigger   = 1'b0;
      rate_tick = 1'b0;
      if (report_valid === 1'b1) begin
        seen = 1'b1;
        check(report, {x, y, prox, b});
      end
    end
    check(36'(seen), 36'(want));
  endtask

  task automatic set_step(input logic [7:0] cmd, input logic [6:0] s);
    i_host.send_setting(cmd, s);
    idle(3);
  endtask

  initial begin
    #500000;
    n_fail++;
    close_out();
  end

  initial begin
    void'($urandom(32'he16a));
    sys_rst      = 1'b1;
    reset_cmd    = 1'b0;
    report_mode  = TRF_MODE_REMOTE;
    trigger      = 1'b0;
    rate_tick    = 1'b0;
    sample_valid = 1'b0;
    sample_pos   = '0;
    prox         = 1'b1;
    buttons      = 3'h0;
    n_fail       = 0;
    checked      = 0;
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    idle(1);
    check(36'(increment_step), 36'h0);
    check(36'(axis_step), 36'h0);
    check(36'(resolution_lpi), 36'd200);
    for (int k = 0; k < 3; k++) begin
      v = (k == 0) ? 7'd95 : 7'($urandom_range(94, 1));
      set_step(TRF_CMD_INCR, v);
      check(36'(increment_step), 36'(v));
      i_host.send(TRF_CMD_QUERY_Z);
      i_host.send(TRF_CMD_QUERY_I);
      qv = 'x;
      for (int i = 0; i < 6; i++) begin
        @(negedge clk);
        if (query_valid === 1'b1) begin
          qv = query_value;
        end
      end
      check(36'(qv), 36'(query_exp(v)));
    end
    set_step(TRF_CMD_INCR, 7'h70);
    check(36'(increment_step), 36'(v));
    i_host.send(TRF_CMD_INCR);
    i_host.send(8'h10);
    idle(3);
    check(36'(increment_step), 36'(v));
    for (int k = 0; k < 11; k++) begin
      i_host.send(RES_CODE[k]);
      idle(3);
      check(36'(resolution_lpi), 36'(RES_LPI[k]));
    end
    set_step(TRF_CMD_AXIS, 7'd33);
    check(36'(axis_step), 36'd33);
    @(negedge clk);
    reset_cmd = 1'b1;
    @(negedge clk);
    reset_cmd = 1'b0;
    idle(3);
    check(36'({increment_step, axis_step, resolution_lpi}), 36'(11'd200));
    // remote request with increment 10
    set_step(TRF_CMD_INCR, 7'd10);
    strobe(1'b0);
    watch(1'b1, 16'd0, 16'd0, 3'h0);
    samp(16'd7, 16'd3);
    strobe(1'b0);
    watch(1'b1, 16'd7, 16'd3, 3'h0);
    samp(16'd9, 16'd5);
    strobe(1'b0);
    watch(1'b1, 16'd7, 16'd3, 3'h0);
    samp(16'd17, 16'd4);
    strobe(1'b0);
    watch(1'b1, 16'd17, 16'd4, 3'h0);
    // stream with increment
    report_mode = TRF_MODE_STREAM;
    samp(16'd20, 16'd6);
    strobe(1'b1);
    watch(1'b0, 16'd0, 16'd0, 3'h0);
    samp(16'd18, 16'd14);
    strobe(1'b1);
    watch(1'b1, 16'd18, 16'd14, 3'h0);
    buttons = 3'h1;
    watch(1'b1, 16'd18, 16'd14, 3'h1);
    buttons = 3'h0;
    watch(1'b1, 16'd18, 16'd14, 3'h0);
    // switch stream, nothing pending
    report_mode = TRF_MODE_SWITCH;
    buttons = 3'h2;
    watch(1'b1, 16'd18, 16'd14, 3'h2);
    strobe(1'b1);
    watch(1'b0, 16'd0, 16'd0, 3'h0);
    buttons = 3'h0;
    samp(16'd19, 16'd15);
    // point mode ignores the filter
    report_mode = TRF_MODE_POINT;
    idle(2);
    prox    = 1'b0;
    buttons = 3'h4;
    watch(1'b1, 16'd19, 16'd15, 3'h4);
    buttons = 3'h0;
    prox    = 1'b1;
    idle(2);
    // axis update with step 10
    set_step(TRF_CMD_INCR, 7'd0);
    check(36'(increment_step), 36'h0);
    set_step(TRF_CMD_AXIS, 7'd10);
    report_mode = TRF_MODE_STREAM;
    samp(16'd100, 16'd200);
    strobe(1'b1);
    watch(1'b1, 16'd100, 16'd200, 3'h0);
    samp(16'd113, 16'd203);
    strobe(1'b1);
    watch(1'b1, 16'd110, 16'd200, 3'h0);
    samp(16'd114, 16'd204);
    strobe(1'b1);
    watch(1'b0, 16'd0, 16'd0, 3'h0);
    samp(16'd111, 16'd212);
    strobe(1'b1);
    watch(1'b1, 16'd110, 16'd210, 3'h0);
    // pointer steps out one grid cell and back before the next slot
    samp(16'd121, 16'd210);
    samp(16'd109, 16'd210);
    strobe(1'b1);
    watch(1'b0, 16'd0, 16'd0, 3'h0);
    set_step(TRF_CMD_AXIS, 7'd0);
    check(36'(axis_step), 36'h0);
    samp(16'd5, 16'd6);
    strobe(1'b1);
    watch(1'b1, 16'd5, 16'd6, 3'h0);
    report_mode = TRF_MODE_REMOTE;
    strobe(1'b0);
    watch(1'b1, 16'd5, 16'd6, 3'h0);
    close_out();
  end
endmodule
